// ---- core/bth_defines.svh ----
`ifndef BTH_DEFINES_SVH
`define BTH_DEFINES_SVH
// register indices; the byte address of each is four times its index
`define BTH_IDX_HEADER 8'h0E
`define BTH_IDX_SELFTEST 8'h0F
`define BTH_IDX_BASE0 8'h10
`define BTH_IDX_BASE1 8'h14
`define BTH_IDX_UP_BUS 8'h18
`define BTH_IDX_DN_BUS 8'h19
`define BTH_IDX_HI_BUS 8'h1A
`define BTH_IDX_LAT 8'h1B
`define BTH_IDX_IO_LOW 8'h1C
`define BTH_IDX_IO_HIGH 8'h1D
// fixed read values
`define BTH_HEADER_VAL 8'h01
`define BTH_SELFTEST_VAL 8'h00
`define BTH_BASE_VAL 32'h0000_0000
`define BTH_LAT_VAL 8'h00
// reset values
`define BTH_RST_BUS 8'h00
`define BTH_RST_CAP 1'h1
`define BTH_RST_IO_LOW 4'hF
`define BTH_RST_IO_HIGH 4'h0
// field positions inside the i/o window bytes
`define BTH_CAP_BIT 0
`define BTH_WIN_MSB 7
`define BTH_WIN_LSB 4
`endif

// ---- core/bth_pkg.sv ----
`default_nettype none
package bth_pkg;
  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BTH_ST_IDLE = 2'b01,
    BTH_ST_ACK = 2'b10
  } bth_bus_e;
  // one i/o transaction offered for a forwarding decision
  typedef struct packed {
    logic valid; // request present this cycle
    logic from_dn; // 1: seen on the downstream side
    logic [31:0] addr; // i/o address
  } bth_io_req_s;
  // forwarding answer
  typedef struct packed {
    logic valid; // decision present
    logic fwd; // 1: cross the bridge
  } bth_io_ans_s;
  // whole state of the register bank
  typedef struct packed {
    bth_bus_e st;
    logic stall; // waitrequest as driven on the pin
    logic [31:0] rdata;
    logic [7:0] up_bus;
    logic [7:0] dn_bus;
    logic [7:0] hi_bus;
    logic cap;
    logic [3:0] io_low;
    logic [3:0] io_high;
    bth_io_ans_s ans;
  } bth_state_s;
endpackage
`default_nettype wire

// ---- core/bth_io_decode.sv ----
`include "bth_defines.svh"
`default_nettype none
// combinational i/o window decode; the caller registers the answer
module bth_io_decode (
  input wire bth_pkg::bth_io_req_s req, // transaction to judge
  input wire logic [3:0] io_low, // window base, address bits 15:12
  input wire logic [3:0] io_high, // window limit, address bits 15:12
  output logic fwd // 1: forward across the bridge
);
  import bth_pkg::*;
  logic in_win; // address lies inside the window
  // upper halves of a 32-bit window live elsewhere and read as zero here,
  // so only the low 64 KB can ever hit; base above limit closes the window
  always_comb begin
    in_win = (req.addr[31:16] == 16'h0000) &&
             (req.addr[15:12] >= io_low) &&
             (req.addr[15:12] <= io_high);
    // downstream traffic crosses only when it misses the window
    fwd = req.from_dn ? !in_win : in_win;
  end
endmodule
`default_nettype wire

// ---- core/bth_regs.sv ----
// Implementation choice: register access over Avalon-MM.
`include "bth_defines.svh"
`default_nettype none
// Functional notes
// - header type reads fixed 0x01
// - self-test register reads fixed zero
// - both base address registers read zero
// - upstream bus number: read/write, reset zero
// - downstream bus number: read/write, reset zero
// - highest bus behind: read/write, reset zero
// - downstream latency timer reads fixed zero
// - width select resets to one, 32-bit
// - window base bits 7:4 writable, reset 0xF
// - window limit bits 7:4 writable, reset zero
// - limit bit 0 mirrors width select
// - window decides which i/o crosses bridge
module bth_regs (
  input wire logic ref_clk, // core clock, 100 MHz
  input wire logic rst, // synchronous, active high
  input wire logic [7:0] avs_address, // word index of the register
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [3:0] avs_byteenable, // byte lanes of the write
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data, valid with waitrequest low
  output logic avs_waitrequest, // high until the access is answered
  input wire logic cap_unlock, // 1: width select may be written
  input wire bth_pkg::bth_io_req_s io_req, // transaction to judge
  output bth_pkg::bth_io_ans_s io_ans, // registered forwarding decision
  output logic [7:0] dn_bus_num, // downstream bus number in use
  output logic [7:0] hi_bus_num // highest bus number behind
);
  import bth_pkg::*;

  bth_state_s s_q; // registered state
  bth_state_s s_d; // next state
  logic fwd_c; // raw decode answer
  logic acc; // an access is pending
  logic commit; // the edge at which the access completes

  // true for every index that this bank answers
  function automatic logic idx_mapped(input logic [7:0] a);
    case (a)
      `BTH_IDX_HEADER, `BTH_IDX_SELFTEST, `BTH_IDX_BASE0, `BTH_IDX_BASE1,
      `BTH_IDX_UP_BUS, `BTH_IDX_DN_BUS, `BTH_IDX_HI_BUS, `BTH_IDX_LAT,
      `BTH_IDX_IO_LOW, `BTH_IDX_IO_HIGH: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  // window decode lives apart so the forwarding path can reuse it
  bth_io_decode u_dec (
    .req(io_req),
    .io_low(s_q.io_low),
    .io_high(s_q.io_high),
    .fwd(fwd_c)
  );

  // read value of one index; unmapped and reserved bits give zero
  function automatic logic [31:0] rd_mux(input bth_state_s s, input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    if (idx_mapped(a)) begin
      case (a)
        `BTH_IDX_HEADER: rd_mux[7:0] = `BTH_HEADER_VAL;
        `BTH_IDX_SELFTEST: rd_mux[7:0] = `BTH_SELFTEST_VAL;
        `BTH_IDX_BASE0, `BTH_IDX_BASE1: rd_mux = `BTH_BASE_VAL;
        `BTH_IDX_UP_BUS: rd_mux[7:0] = s.up_bus;
        `BTH_IDX_DN_BUS: rd_mux[7:0] = s.dn_bus;
        `BTH_IDX_HI_BUS: rd_mux[7:0] = s.hi_bus;
        `BTH_IDX_LAT: rd_mux[7:0] = `BTH_LAT_VAL;
        `BTH_IDX_IO_LOW: begin
          rd_mux[`BTH_WIN_MSB:`BTH_WIN_LSB] = s.io_low;
          rd_mux[`BTH_CAP_BIT] = s.cap;
        end
        `BTH_IDX_IO_HIGH: begin
          rd_mux[`BTH_WIN_MSB:`BTH_WIN_LSB] = s.io_high;
          rd_mux[`BTH_CAP_BIT] = s.cap;
        end
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  // next-state logic: bus handshake, register writes, forwarding answer
  always_comb begin
    s_d = s_q;
    acc = avs_read || avs_write;
    commit = 1'b0;
    case (s_q.st)
      BTH_ST_IDLE: begin
        // one wait cycle lets read data come from a flop
        if (acc) begin
          s_d.st = BTH_ST_ACK;
          s_d.stall = 1'b0;
          s_d.rdata = avs_read ? rd_mux(s_q, avs_address) : 32'h0000_0000;
        end
      end
      BTH_ST_ACK: begin
        // master samples waitrequest low at this edge and completes
        commit = 1'b1;
        s_d.st = BTH_ST_IDLE;
        s_d.stall = 1'b1;
        s_d.rdata = 32'h0000_0000;
      end
      default: begin
        // illegal code: fall back to idle, waitrequest high
        s_d.st = BTH_ST_IDLE;
        s_d.stall = 1'b1;
      end
    endcase
    // writes take effect only at the completing edge, lane 0 only;
    // fixed registers and reserved bits have no storage, so writes vanish
    if (commit && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        `BTH_IDX_UP_BUS: s_d.up_bus = avs_writedata[7:0];
        `BTH_IDX_DN_BUS: s_d.dn_bus = avs_writedata[7:0];
        `BTH_IDX_HI_BUS: s_d.hi_bus = avs_writedata[7:0];
        `BTH_IDX_IO_LOW: begin
          s_d.io_low = avs_writedata[`BTH_WIN_MSB:`BTH_WIN_LSB];
          // width select is locked unless the strap input opens it
          if (cap_unlock) begin
            s_d.cap = avs_writedata[`BTH_CAP_BIT];
          end
        end
        `BTH_IDX_IO_HIGH: s_d.io_high = avs_writedata[`BTH_WIN_MSB:`BTH_WIN_LSB];
        default: s_d.st = s_d.st; // read-only or unmapped: nothing stored
      endcase
    end
    // forwarding decision, one cycle after the request
    s_d.ans.valid = io_req.valid;
    s_d.ans.fwd = io_req.valid && fwd_c;
    if (rst) begin
      s_d.st = BTH_ST_IDLE;
      s_d.stall = 1'b1;
      s_d.rdata = 32'h0000_0000;
      s_d.up_bus = `BTH_RST_BUS;
      s_d.dn_bus = `BTH_RST_BUS;
      s_d.hi_bus = `BTH_RST_BUS;
      s_d.cap = `BTH_RST_CAP;
      s_d.io_low = `BTH_RST_IO_LOW;
      s_d.io_high = `BTH_RST_IO_HIGH;
      s_d.ans = '0;
    end
  end

  // single state register; reset is folded into the next value
  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  // outputs come straight from the state flops; waitrequest has a flop of
  // its own rather than an inverter, so no gate sits between flop and pin
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.stall;
  assign io_ans = s_q.ans;
  assign dn_bus_num = s_q.dn_bus;
  assign hi_bus_num = s_q.hi_bus;

  // a completed read of a fixed register shows its constant
  header_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_HEADER)
      |-> avs_readdata == {24'h00_0000, `BTH_HEADER_VAL})
    else $error("header type read is not 0x01");
  selftest_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_SELFTEST)
      |-> avs_readdata == 32'h0000_0000)
    else $error("self-test read is not zero");
  bar_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read &&
     (avs_address == `BTH_IDX_BASE0 || avs_address == `BTH_IDX_BASE1))
      |-> avs_readdata == 32'h0000_0000)
    else $error("base address register read is not zero");
  latency_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_LAT)
      |-> avs_readdata == 32'h0000_0000)
    else $error("latency timer read is not zero");

  // a completed write lands in the addressed bus number the next cycle
  up_bus_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && avs_byteenable[0] &&
     avs_address == `BTH_IDX_UP_BUS) |=> s_q.up_bus == $past(avs_writedata[7:0]))
    else $error("upstream bus number write lost");
  dn_bus_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && avs_byteenable[0] &&
     avs_address == `BTH_IDX_DN_BUS) |=> dn_bus_num == $past(avs_writedata[7:0]))
    else $error("downstream bus number write lost");
  hi_bus_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && avs_byteenable[0] &&
     avs_address == `BTH_IDX_HI_BUS) |=> hi_bus_num == $past(avs_writedata[7:0]))
    else $error("highest bus number write lost");

  // reset values seen right after release
  window_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> (s_q.cap == 1'b1 && s_q.io_low == 4'hF && s_q.io_high == 4'h0 &&
                    dn_bus_num == 8'h00))
    else $error("window fields not at reset values");

  // limit bit 0 mirrors the width select; reserved bits read zero
  limit_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_IO_HIGH)
      |-> (avs_readdata[0] == s_q.cap && avs_readdata[7:4] == s_q.io_high))
    else $error("limit register read wrong");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read &&
     (avs_address == `BTH_IDX_IO_LOW || avs_address == `BTH_IDX_IO_HIGH))
      |-> (avs_readdata[3:1] == 3'h0 && avs_readdata[31:8] == 24'h000000))
    else $error("reserved bits read non-zero");

  // width select holds while locked
  cap_locked_a: assert property (@(posedge ref_clk) disable iff (rst)
    !cap_unlock |=> $stable(s_q.cap))
    else $error("locked width select changed");

  // forwarding answer follows the window one cycle later
  fwd_decide_a: assert property (@(posedge ref_clk) disable iff (rst)
    (io_req.valid && !io_req.from_dn && io_req.addr[31:16] == 16'h0000 &&
     io_req.addr[15:12] >= s_q.io_low && io_req.addr[15:12] <= s_q.io_high)
      |=> (io_ans.valid && io_ans.fwd))
    else $error("in-window upstream i/o not forwarded");

  // every request is answered within two edges
  bus_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(avs_read) || $rose(avs_write)) |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered in time");

  // one-hot state code only ever holds one of its two legal values
  state_onehot_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == BTH_ST_IDLE || s_q.st == BTH_ST_ACK))
    else $error("bus state left its legal codes");

  // waitrequest drops for one cycle per access; read data is zero outside it,
  // so a master that samples late sees zero rather than a stale value
  wait_one_cycle_a: assert property (@(posedge ref_clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    avs_waitrequest |-> avs_readdata == 32'h0000_0000)
    else $error("read data not zero while stalled");

  // the rest of the reset values, checked at the first edge after release
  bus_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> (s_q.up_bus == 8'h00 && hi_bus_num == 8'h00 && avs_waitrequest))
    else $error("bus numbers not at reset values");

  // a completed read of a bus number shows the stored value
  up_bus_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_UP_BUS)
      |-> avs_readdata == {24'h00_0000, s_q.up_bus})
    else $error("upstream bus number read wrong");
  dn_bus_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_DN_BUS)
      |-> avs_readdata == {24'h00_0000, dn_bus_num})
    else $error("downstream bus number read wrong");
  hi_bus_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_HI_BUS)
      |-> avs_readdata == {24'h00_0000, hi_bus_num})
    else $error("highest bus number read wrong");

  // window writes land in their fields the next cycle
  io_low_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && avs_byteenable[0] &&
     avs_address == `BTH_IDX_IO_LOW) |=> s_q.io_low == $past(avs_writedata[7:4]))
    else $error("window base write lost");
  io_high_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && avs_byteenable[0] &&
     avs_address == `BTH_IDX_IO_HIGH) |=> s_q.io_high == $past(avs_writedata[7:4]))
    else $error("window limit write lost");
  // the width select takes a write only while the strap input opens it
  cap_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && avs_byteenable[0] && cap_unlock &&
     avs_address == `BTH_IDX_IO_LOW) |=> s_q.cap == $past(avs_writedata[0]))
    else $error("unlocked width select write lost");
  low_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_read && avs_address == `BTH_IDX_IO_LOW)
      |-> (avs_readdata[0] == s_q.cap && avs_readdata[7:4] == s_q.io_low))
    else $error("base register read wrong");

  // writes with lane 0 off, or to a fixed or unmapped index, store nothing
  lane_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && !avs_byteenable[0])
      |=> ($stable(s_q.up_bus) && $stable(s_q.dn_bus) && $stable(s_q.hi_bus) &&
           $stable(s_q.io_low) && $stable(s_q.io_high) && $stable(s_q.cap)))
    else $error("write with lane 0 off changed a register");
  fixed_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!avs_waitrequest && avs_write && avs_address != `BTH_IDX_UP_BUS &&
     avs_address != `BTH_IDX_DN_BUS && avs_address != `BTH_IDX_HI_BUS &&
     avs_address != `BTH_IDX_IO_LOW && avs_address != `BTH_IDX_IO_HIGH)
      |=> ($stable(s_q.up_bus) && $stable(s_q.dn_bus) && $stable(s_q.hi_bus) &&
           $stable(s_q.io_low) && $stable(s_q.io_high) && $stable(s_q.cap)))
    else $error("write to a fixed index changed a register");

  // in-window test for the forwarding checks below; kept apart from the
  // decoder so that a fault there cannot hide itself
  function automatic logic win_hit(input bth_io_req_s r, input logic [3:0] lo,
                                   input logic [3:0] hi);
    win_hit = (r.addr[31:16] == 16'h0000) && (r.addr[15:12] >= lo) &&
              (r.addr[15:12] <= hi);
  endfunction

  // the other three cases of the forwarding decision, and the idle answer
  fwd_up_miss_a: assert property (@(posedge ref_clk) disable iff (rst)
    (io_req.valid && !io_req.from_dn && !win_hit(io_req, s_q.io_low, s_q.io_high))
      |=> (io_ans.valid && !io_ans.fwd))
    else $error("upstream i/o outside the window forwarded");
  fwd_dn_hit_a: assert property (@(posedge ref_clk) disable iff (rst)
    (io_req.valid && io_req.from_dn && win_hit(io_req, s_q.io_low, s_q.io_high))
      |=> (io_ans.valid && !io_ans.fwd))
    else $error("downstream i/o inside the window forwarded");
  fwd_dn_miss_a: assert property (@(posedge ref_clk) disable iff (rst)
    (io_req.valid && io_req.from_dn && !win_hit(io_req, s_q.io_low, s_q.io_high))
      |=> (io_ans.valid && io_ans.fwd))
    else $error("downstream i/o outside the window not forwarded");
  ans_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    !io_req.valid |=> (!io_ans.valid && !io_ans.fwd))
    else $error("forwarding answer without a request");
endmodule
`default_nettype wire

// ---- dv/bridge_type1_header_io_window_test.sv ----
`default_nettype none
module bridge_type1_header_io_window_test import bth_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk; // core clock
  logic rst; // synchronous reset
  logic [7:0] avs_address; // register word index
  logic avs_read, avs_write; // bus requests
  logic [3:0] avs_byteenable; // write lanes
  logic [31:0] avs_writedata, avs_readdata; // bus data
  logic avs_waitrequest; // slave stall
  logic cap_unlock; // width select write permit
  bth_io_req_s io_req; // transaction offered
  bth_io_ans_s io_ans; // forwarding answer
  logic [7:0] dn_bus_num, hi_bus_num; // bus number outputs
  int fails = 0; // mismatches
  int cmp_count = 0; // comparisons

  bth_regs bth_regs_inst (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_unlock(cap_unlock), .io_req(io_req),
    .io_ans(io_ans), .dn_bus_num(dn_bus_num), .hi_bus_num(hi_bus_num));

  // free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // single compare point, counts every check
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one bus access; held until waitrequest is sampled low, gap cycle before the next
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= idx;
    avs_writedata <= wd;
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    // a hang is left to the watchdog; the slave answers after one wait cycle
    chk("bus answer edges", 32'h0000_0002, n);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus(1'b1, idx, {24'hFFFF_FF, d}, 4'hF, unused);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, idx, 32'h0, 4'h0, got);
    chk(what, exp, got);
  endtask

  // every mapped register at its documented reset value
  task automatic reset_values();
    rd_chk("header type", 8'h0E, 32'h01);
    rd_chk("self test", 8'h0F, 32'h00);
    rd_chk("base addr 0", 8'h10, 32'h0);
    rd_chk("base addr 1", 8'h14, 32'h0);
    rd_chk("upstream bus", 8'h18, 32'h00);
    rd_chk("downstream bus", 8'h19, 32'h00);
    rd_chk("highest bus", 8'h1A, 32'h00);
    rd_chk("latency timer", 8'h1B, 32'h00);
    rd_chk("window low", 8'h1C, 32'hF1);
    rd_chk("window high", 8'h1D, 32'h01);
    chk("answer after reset", 32'h0, {30'h0, io_ans});
  endtask

  // fixed registers and an unmapped index shrug off writes
  task automatic read_only_writes();
    wr8(8'h0E, 8'hFF);
    wr8(8'h0F, 8'hFF);
    wr8(8'h10, 8'hFF);
    wr8(8'h14, 8'hFF);
    wr8(8'h1B, 8'hFF);
    wr8(8'h30, 8'hFF);
    rd_chk("header type kept", 8'h0E, 32'h01);
    rd_chk("self test kept", 8'h0F, 32'h00);
    rd_chk("base addr 0 kept", 8'h10, 32'h0);
    rd_chk("base addr 1 kept", 8'h14, 32'h0);
    rd_chk("latency kept", 8'h1B, 32'h00);
    rd_chk("unmapped index", 8'h30, 32'h0);
  endtask

  // bus numbers take writes, lane 0 off leaves them alone
  task automatic bus_numbers();
    logic [31:0] unused;
    wr8(8'h18, 8'hA5);
    wr8(8'h19, 8'h5A);
    wr8(8'h1A, 8'hC3);
    bus(1'b1, 8'h19, 32'h0000_0011, 4'hE, unused);
    rd_chk("upstream bus", 8'h18, 32'hA5);
    rd_chk("downstream bus", 8'h19, 32'h5A);
    rd_chk("highest bus", 8'h1A, 32'hC3);
    chk("downstream port", 32'h5A, {24'h0, dn_bus_num});
    chk("highest port", 32'hC3, {24'h0, hi_bus_num});
  endtask

  // window fields, reserved bits and the locked width select
  task automatic window_regs();
    wr8(8'h1C, 8'h2E);
    wr8(8'h1D, 8'h4F);
    rd_chk("low locked cap", 8'h1C, 32'h21);
    rd_chk("high mirror", 8'h1D, 32'h41);
    @(posedge ref_clk);
    cap_unlock <= 1'b1;
    wr8(8'h1C, 8'h20);
    rd_chk("low 16-bit", 8'h1C, 32'h20);
    rd_chk("high mirror 0", 8'h1D, 32'h40);
    wr8(8'h1C, 8'h21);
    @(posedge ref_clk);
    cap_unlock <= 1'b0;
  endtask

  // decision for one transaction, one cycle later
  task automatic io_chk(input logic dn, input logic [31:0] a);
    logic inw;
    inw = (a[31:16] == 16'h0) && (a[15:12] >= 4'h2) && (a[15:12] <= 4'h4);
    @(posedge ref_clk);
    io_req <= '{valid: 1'b1, from_dn: dn, addr: a};
    @(posedge ref_clk);
    #1;
    chk("forward answer", {30'h0, 1'b1, dn ? !inw : inw}, {30'h0, io_ans});
  endtask

  // window 0x2000..0x4FFF, both directions, edges on each side
  task automatic forwarding();
    logic [31:0] adr [6] = '{32'h1FFF, 32'h2000, 32'h3000, 32'h4FFF, 32'h5000, 32'h1_3000};
    for (int d = 0; d < 2; d++) begin
      foreach (adr[i]) io_chk(d[0], adr[i]);
    end
    @(posedge ref_clk);
    io_req <= '{valid: 1'b0, from_dn: 1'b0, addr: 32'h3000};
    @(posedge ref_clk);
    #1;
    chk("idle answer", 32'h0, {30'h0, io_ans});
  endtask

  // a second reset in mid-run puts every written field back
  task automatic reset_again();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("waitrequest in reset", 32'h0000_0001, {31'h0, avs_waitrequest});
    rst <= 1'b0;
    reset_values();
    chk("downstream port reset", 32'h0, {24'h0, dn_bus_num});
    chk("highest port reset", 32'h0, {24'h0, hi_bus_num});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a hung handshake must not stall the run
  initial begin
    repeat (4000) @(posedge ref_clk);
    fails++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    cap_unlock = 1'b0;
    io_req = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    reset_values();
    read_only_writes();
    bus_numbers();
    window_regs();
    forwarding();
    reset_again();
    final_report();
  end
endmodule
`default_nettype wire
